// File: emac_queue_status.sv
// MAC DMA side status and queue pointer registers behind an APB slave.
// Assumes engine events are one-cycle pulses on SYS_CLK_I; the
// management data pin is asynchronous and synchronised here.
//
// How it works
// - Status bit shows live management pin
// - Idle bit high when management finished
// - Write one clears status, zero keeps
// - Used descriptor fetch sets bit 0
// - Collision sets bit 1
// - Retry limit sets bit 2, write clears
// - Bit 3 shows transmit active, read-only
// - Exhausted mid-frame: stop, bad FCS, error
// - Each finished frame sets bit 5
// - DMA underrun sets bit 6
// - Underrun corrupts frame check sequence
// - Pointers walk, wrap at 1024 or bit
// - Receive pointer reads current descriptor
// - Transmit pointer reads frame first descriptor
// - Owned buffer refetched at next frame
// - Every failed acquisition sets bit 0
// - Stored frame sets receive bit 1
// - Receive overrun sets bit 2, reclaims
// - Transmit disable stops, flushes, resets pointer
// - Receive disable stops, flushes, keeps pointer
`default_nettype none

module emac_queue_status #(
   parameter int IDX_W = 10  // Entries before wrap, as log2
) (
   // Clock and reset
   input  wire logic                 SYS_CLK_I,
   input  wire logic                 RESETN_I,
   // APB slave
   input  wire logic                 PSEL_I,
   input  wire logic                 PENABLE_I,
   input  wire logic                 PWRITE_I,
   input  wire logic           [7:0] PADDR_I,
   input  wire logic          [31:0] PWDATA_I,
   output logic               [31:0] PRDATA_O,
   output logic                      PREADY_O,
   output logic                      PSLVERR_O,
   // Management side
   input  wire logic                 MDIO_PIN_I,
   input  wire logic                 MGMT_BUSY_I,
   // Transmit engine
   input  wire logic                 TX_ACTIVE_I,
   input  wire emac_qs_pkg::tx_evt_s TX_EVT_I,
   input  wire logic                 TX_DESC_ADV_I,
   input  wire logic                 TX_DESC_WRAP_I,
   // Receive engine
   input  wire emac_qs_pkg::rx_evt_s RX_EVT_I,
   input  wire logic                 RX_FRAME_START_I,
   input  wire logic                 RX_DESC_ADV_I,
   input  wire logic                 RX_DESC_WRAP_I,
   // Controls towards the engines
   output logic                      TRANSMIT_ENABLE_O,
   output logic                      RECEIVE_ENABLE_O,
   output logic                      TX_STOP_O,
   output logic                      TX_FLUSH_O,
   output logic                      RX_FLUSH_O,
   output logic                      TX_ER_O,
   output logic                      TX_BAD_FCS_O,
   output logic                      RX_REFETCH_O,
   // Current descriptor addresses for the DMA
   output logic               [31:0] TX_DESC_ADDR_O,
   output logic               [31:0] RX_DESC_ADDR_O
);

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   wire logic setup_w  = PSEL_I && !PENABLE_I;
   wire logic access_w = PSEL_I && PENABLE_I;
   wire logic wr_w     = access_w && PWRITE_I;
   wire logic hit_ctl_w;
   wire logic hit_ns_w;
   wire logic hit_ts_w;
   wire logic hit_rq_w;
   wire logic hit_tq_w;
   wire logic hit_rs_w;
   wire logic mapped_w;

   assign hit_ctl_w = (PADDR_I == emac_qs_pkg::OFS_CONTROL);
   assign hit_ns_w  = (PADDR_I == emac_qs_pkg::OFS_NET_STATUS);
   assign hit_ts_w  = (PADDR_I == emac_qs_pkg::OFS_TX_STATUS);
   assign hit_rq_w  = (PADDR_I == emac_qs_pkg::OFS_RX_QPTR);
   assign hit_tq_w  = (PADDR_I == emac_qs_pkg::OFS_TX_QPTR);
   assign hit_rs_w  = (PADDR_I == emac_qs_pkg::OFS_RX_STATUS);
   assign mapped_w  = hit_ctl_w || hit_ns_w || hit_ts_w || hit_rq_w
                    || hit_tq_w || hit_rs_w;

   // Zero wait states; read data is captured in the setup cycle
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = access_w && !mapped_w;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic        mdio_s1_q;   // First synchroniser stage
   logic        mdio_s2_q;   // Safe pin level
   logic        tx_en_q;     // transmit_enable
   logic        rx_en_q;     // receive_enable
   logic [6:0]  ts_q;        // Transmit status flags
   logic [6:0]  ts_d;
   logic [2:0]  rs_q;        // Receive status flags
   logic [2:0]  rs_d;
   logic [31:0] rdata_q;     // Read data register
   logic        stop_q;      // Transmit stop pulse
   logic        txf_q;       // Transmit flush pulse
   logic        rxf_q;       // Receive flush pulse
   logic        txer_q;      // Transmit error pulse
   logic        fcs_q;       // Bad check sequence pulse
   logic        refetch_q;   // Descriptor refetch pulse
   emac_qs_pkg::rx_acq_e acq_q;  // Receive buffer acquisition
   emac_qs_pkg::rx_acq_e acq_d;
   logic [31:0] tx_cur_w;    // Transmit current entry
   logic [31:0] tx_first_w;  // First entry of current frame
   logic [31:0] rx_cur_w;    // Receive current entry
   logic [31:0] ts_view_w;   // Transmit status as read
   logic [31:0] ns_view_w;   // Network status as read

   // -----------------------------------------------------------------
   // Software side controls
   // -----------------------------------------------------------------
   wire logic ctl_wr_w = wr_w && hit_ctl_w;
   wire logic tx_off_w = ctl_wr_w && tx_en_q && !PWDATA_I[emac_qs_pkg::CTL_TX_EN];
   wire logic rx_off_w = ctl_wr_w && rx_en_q && !PWDATA_I[emac_qs_pkg::CTL_RX_EN];
   // Transmit pointer writes during a frame would corrupt the walk, so refused
   wire logic tq_wr_w  = wr_w && hit_tq_w && !TX_ACTIVE_I;
   wire logic rq_wr_w  = wr_w && hit_rq_w;
   wire logic ts_wr_w  = wr_w && hit_ts_w;
   wire logic rs_wr_w  = wr_w && hit_rs_w;

   // -----------------------------------------------------------------
   // Status flags
   // -----------------------------------------------------------------
   // write one clears
   // Hardware set is applied after the clear so it wins
   always_comb begin
      ts_d = ts_q;
      rs_d = rs_q;
      if (ts_wr_w) begin
         ts_d = ts_q & ~PWDATA_I[6:0];
      end
      if (rs_wr_w) begin
         rs_d = rs_q & ~PWDATA_I[2:0];
      end
      ts_d = ts_d | TX_EVT_I;
      rs_d = rs_d | RX_EVT_I;
   end

   // bit 3 is live, ts_q[3] never read
   assign ts_view_w = {25'h000_0000, ts_q[6:4], TX_ACTIVE_I, ts_q[2:0]};

   assign ns_view_w = {29'h0000_0000, !MGMT_BUSY_I, mdio_s2_q, 1'b0};

   // -----------------------------------------------------------------
   // Receive buffer acquisition
   // -----------------------------------------------------------------
   // owned buffer refetch
   // After a failure the engine retries only at the next frame start
   always_comb begin
      acq_d = acq_q;
      case (acq_q)
         emac_qs_pkg::RX_HAVE_BUF: begin
            if (RX_EVT_I.no_buffer) begin
               acq_d = emac_qs_pkg::RX_WAIT_BUF;
            end
         end
         emac_qs_pkg::RX_WAIT_BUF: begin
            if (RX_DESC_ADV_I || rx_off_w) begin
               acq_d = emac_qs_pkg::RX_HAVE_BUF;
            end
         end
         default: begin
            acq_d = emac_qs_pkg::RX_HAVE_BUF;
         end
      endcase
   end

   wire logic refetch_w = (acq_q == emac_qs_pkg::RX_WAIT_BUF) && RX_FRAME_START_I
                        && rx_en_q;

   // -----------------------------------------------------------------
   // Read data mux
   // -----------------------------------------------------------------
   logic [31:0] rmux_w;
   always_comb begin
      rmux_w = 32'h0000_0000;
      if (hit_ctl_w) begin
         rmux_w[emac_qs_pkg::CTL_TX_EN] = tx_en_q;
         rmux_w[emac_qs_pkg::CTL_RX_EN] = rx_en_q;
      end else if (hit_ns_w) begin
         rmux_w = ns_view_w;
      end else if (hit_ts_w) begin
         rmux_w = ts_view_w;
      end else if (hit_rq_w) begin
         rmux_w = rx_cur_w;
      end else if (hit_tq_w) begin
         rmux_w = tx_first_w;
      end else if (hit_rs_w) begin
         rmux_w = {29'h0000_0000, rs_q};
      end
   end

   // -----------------------------------------------------------------
   // Synchroniser for the management pin
   // -----------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         mdio_s1_q <= 1'b0;
         mdio_s2_q <= 1'b0;
      end else begin
         mdio_s1_q <= MDIO_PIN_I;
         mdio_s2_q <= mdio_s1_q;
      end
   end

   // -----------------------------------------------------------------
   // Control and status registers
   // -----------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         tx_en_q <= emac_qs_pkg::CONTROL_RESET[emac_qs_pkg::CTL_TX_EN];
         rx_en_q <= emac_qs_pkg::CONTROL_RESET[emac_qs_pkg::CTL_RX_EN];
         ts_q    <= '0;
         rs_q    <= '0;
         acq_q   <= emac_qs_pkg::RX_HAVE_BUF;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (ctl_wr_w) begin
            tx_en_q <= PWDATA_I[emac_qs_pkg::CTL_TX_EN];
            rx_en_q <= PWDATA_I[emac_qs_pkg::CTL_RX_EN];
         end
         ts_q  <= ts_d;
         rs_q  <= rs_d;
         acq_q <= acq_d;
         if (setup_w && !PWRITE_I) begin
            rdata_q <= rmux_w;
         end
      end
   end

   // -----------------------------------------------------------------
   // Pulses towards the engines
   // -----------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         stop_q    <= 1'b0;
         txf_q     <= 1'b0;
         rxf_q     <= 1'b0;
         txer_q    <= 1'b0;
         fcs_q     <= 1'b0;
         refetch_q <= 1'b0;
      end else begin
         stop_q    <= TX_EVT_I.exhausted || tx_off_w;
         txf_q     <= tx_off_w;
         rxf_q     <= rx_off_w;
         txer_q    <= TX_EVT_I.exhausted;
         fcs_q     <= TX_EVT_I.exhausted || TX_EVT_I.underrun;
         refetch_q <= refetch_w;
      end
   end

   assign PRDATA_O          = rdata_q;
   assign TRANSMIT_ENABLE_O = tx_en_q;
   assign RECEIVE_ENABLE_O  = rx_en_q;
   assign TX_STOP_O         = stop_q;
   assign TX_FLUSH_O        = txf_q;
   assign RX_FLUSH_O        = rxf_q;
   assign TX_ER_O           = txer_q;
   assign TX_BAD_FCS_O      = fcs_q;
   assign RX_REFETCH_O      = refetch_q;
   assign TX_DESC_ADDR_O    = tx_cur_w;
   assign RX_DESC_ADDR_O    = rx_cur_w;

   // -----------------------------------------------------------------
   // Queue pointers
   // -----------------------------------------------------------------
   // restart on disable
   // Mark tracks while idle, so reads show the frame's first entry
   qptr_walker #(.IDX_W(IDX_W)) u_txq (
      .clk_i       (SYS_CLK_I),
      .rst_n_i     (RESETN_I),
      .load_i      (tq_wr_w),
      .load_word_i (PWDATA_I[31:2]),
      .adv_i       (TX_DESC_ADV_I && tx_en_q),
      .wrap_i      (TX_DESC_WRAP_I),
      .restart_i   (tx_off_w),
      .track_i     (!TX_ACTIVE_I),
      .rewind_i    (1'b0),
      .cur_o       (tx_cur_w),
      .first_o     (tx_first_w)
   );

   // reclaim on overrun
   // Disable leaves the walk as it is
   qptr_walker #(.IDX_W(IDX_W)) u_rxq (
      .clk_i       (SYS_CLK_I),
      .rst_n_i     (RESETN_I),
      .load_i      (rq_wr_w),
      .load_word_i (PWDATA_I[31:2]),
      .adv_i       (RX_DESC_ADV_I && rx_en_q),
      .wrap_i      (RX_DESC_WRAP_I),
      .restart_i   (1'b0),
      .track_i     (RX_FRAME_START_I),
      .rewind_i    (RX_EVT_I.overrun),
      .cur_o       (rx_cur_w),
      .first_o     ()
   );

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESETN_I);

   sequence s_read_setup(logic hit);
      setup_w && !PWRITE_I && hit;
   endsequence

   a_mdio_live_read: assert property (
      s_read_setup(hit_ns_w) |=> PRDATA_O[emac_qs_pkg::NS_MDIO] == $past(mdio_s2_q))
      else $error("pin status not live");
   a_idle_bit_read: assert property (
      s_read_setup(hit_ns_w) |=> PRDATA_O[emac_qs_pkg::NS_IDLE] == !$past(MGMT_BUSY_I))
      else $error("idle bit wrong");
   a_w1c_no_set: assert property (
      ts_wr_w && !$past(ts_wr_w) && TX_EVT_I == '0 |=> (ts_q & ~$past(ts_q)) == '0)
      else $error("write set a status bit");
   a_set_beats_clear: assert property (
      TX_EVT_I.used_seen |=> ts_q[0])
      else $error("used bit flag lost");
   a_retry_sticky: assert property (
      ts_q[2] && !ts_wr_w |=> ts_q[2])
      else $error("retry flag dropped without write");
   a_active_live: assert property (
      s_read_setup(hit_ts_w) |=> PRDATA_O[emac_qs_pkg::TS_ACTIVE] == $past(TX_ACTIVE_I))
      else $error("active bit not live");
   a_exhaust_stop: assert property (
      TX_EVT_I.exhausted |=> TX_STOP_O && TX_ER_O && TX_BAD_FCS_O && ts_q[4])
      else $error("exhaustion not handled");
   a_underrun_fcs: assert property (
      TX_EVT_I.underrun |=> TX_BAD_FCS_O && ts_q[6])
      else $error("underrun did not corrupt check");
   a_nobuf_each: assert property (
      RX_EVT_I.no_buffer |=> rs_q[0])
      else $error("no buffer flag not set");
   a_refetch_start: assert property (
      acq_q == emac_qs_pkg::RX_WAIT_BUF && RX_FRAME_START_I && rx_en_q |=> RX_REFETCH_O)
      else $error("no refetch at frame start");
   a_txoff_restart: assert property (
      tx_off_w |=> TX_STOP_O && TX_FLUSH_O && tx_cur_w == tx_first_w)
      else $error("transmit disable did not restart");
   a_rxoff_keeps: assert property (
      rx_off_w && !RX_DESC_ADV_I && !RX_EVT_I.overrun && !rq_wr_w
      |=> RX_FLUSH_O && rx_cur_w == $past(rx_cur_w))
      else $error("receive disable moved pointer");
   a_ptr_aligned: assert property (
      rx_cur_w[1:0] == 2'b00 && tx_first_w[1:0] == 2'b00)
      else $error("pointer not word aligned");

endmodule

`default_nettype wire

// File: emac_qs_pkg.sv
// Shared constants and carriers for the MAC queue and status block.
// Assumes one system clock; all users refer to names with the package scope.
`default_nettype none

package emac_qs_pkg;

   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL    = 8'h00;  // Enables
   localparam logic [7:0] OFS_NET_STATUS = 8'h08;  // Pin and idle status
   localparam logic [7:0] OFS_TX_STATUS  = 8'h14;  // Transmit status
   localparam logic [7:0] OFS_RX_QPTR    = 8'h18;  // Receive queue pointer
   localparam logic [7:0] OFS_TX_QPTR    = 8'h1C;  // Transmit queue pointer
   localparam logic [7:0] OFS_RX_STATUS  = 8'h20;  // Receive status

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CTL_RX_EN   = 2;  // receive_enable
   localparam int CTL_TX_EN   = 3;  // transmit_enable
   localparam int NS_MDIO     = 1;  // Live management data pin
   localparam int NS_IDLE     = 2;  // Management logic idle
   localparam int TS_ACTIVE   = 3;  // transmit_active position
   localparam int TS_BITS     = 7;  // Implemented transmit status bits
   localparam int RS_BITS     = 3;  // Implemented receive status bits

   // -----------------------------------------------------------------
   // Reset values and counts
   // -----------------------------------------------------------------
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [29:0] QPTR_RESET    = 30'h0000_0000;
   localparam int          DESC_COUNT    = 1024;  // Entries before wrap
   localparam int          DESC_WORDS    = 2;     // Words per descriptor

   // -----------------------------------------------------------------
   // Event carriers, one-cycle pulses from the engines
   // -----------------------------------------------------------------
   typedef struct packed {
      logic underrun;     // Bit 6
      logic done;         // Bit 5
      logic exhausted;    // Bit 4
      logic active_rsv;   // Bit 3 place holder, ignored
      logic retry_limit;  // Bit 2
      logic collision;    // Bit 1
      logic used_seen;    // Bit 0
   } tx_evt_s;

   typedef struct packed {
      logic overrun;    // Bit 2
      logic stored;     // Bit 1
      logic no_buffer;  // Bit 0
   } rx_evt_s;

   // Receive buffer acquisition state
   typedef enum logic {RX_HAVE_BUF, RX_WAIT_BUF} rx_acq_e;

endpackage

`default_nettype wire

// File: qptr_walker.sv
// Descriptor queue pointer: base, walking index, frame mark.
// Assumes pulses from the DMA engine on the same clock as the bus.
`default_nettype none

module qptr_walker #(
   parameter int IDX_W = 10  // log2 of descriptors before wrap
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Software load of list start
   input  wire logic        load_i,
   input  wire logic [29:0] load_word_i,
   // Engine controls
   input  wire logic        adv_i,
   input  wire logic        wrap_i,
   input  wire logic        restart_i,
   input  wire logic        track_i,
   input  wire logic        rewind_i,
   // Pointers, word aligned
   output logic      [31:0] cur_o,
   output logic      [31:0] first_o
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [29:0]      base_q;  // List start, word address
   logic [IDX_W-1:0] idx_q;   // Current entry
   logic [IDX_W-1:0] idx_d;
   logic [IDX_W-1:0] mark_q;  // First entry of frame
   logic [IDX_W-1:0] mark_d;
   wire  logic       last_w = (idx_q == {IDX_W{1'b1}});

   // index walk and wrap
   // Wrap bit or the last of 1024 entries return to the start
   always_comb begin
      idx_d = idx_q;
      if (load_i || restart_i) begin
         idx_d = '0;
      end else if (rewind_i) begin
         idx_d = mark_q;
      end else if (adv_i) begin
         idx_d = (wrap_i || last_w) ? '0 : idx_q + 1'b1;
      end
   end

   // Mark follows the walk while asked to
   always_comb begin
      mark_d = mark_q;
      if (load_i || restart_i) begin
         mark_d = '0;
      end else if (track_i) begin
         mark_d = idx_d;
      end
   end

   // Registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         base_q <= emac_qs_pkg::QPTR_RESET;
         idx_q  <= '0;
         mark_q <= '0;
      end else begin
         if (load_i) begin
            base_q <= load_word_i;
         end
         idx_q  <= idx_d;
         mark_q <= mark_d;
      end
   end

   // low two bits zero
   // Two words per entry, so the index is doubled
   assign cur_o   = {base_q + 30'({idx_q, 1'b0}), 2'b00};
   assign first_o = {base_q + 30'({mark_q, 1'b0}), 2'b00};

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_ptr_wrap_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      adv_i && wrap_i && !load_i && !restart_i && !rewind_i |=> idx_q == '0)
      else $error("pointer did not wrap to start");
   a_ptr_adv_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      adv_i && !wrap_i && !last_w && !load_i && !restart_i && !rewind_i
      |=> idx_q == $past(idx_q) + 1'b1)
      else $error("pointer did not step by one");

endmodule

`default_nettype wire

// File: emac_dma_model.sv
// Model of the DMA engines facing system memory.
// Assumes the bench changes req_i just after a rising edge.
`default_nettype none
module emac_dma_model (
   // Request bits from the bench
   input  wire logic [14:0]        req_i,
   // Engine pulses towards the block
   output var emac_qs_pkg::tx_evt_s tx_evt_o,
   output var emac_qs_pkg::rx_evt_s rx_evt_o,
   output var logic                tx_adv_o,
   output var logic                tx_wrap_o,
   output var logic                rx_start_o,
   output var logic                rx_adv_o,
   output var logic                rx_wrap_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Plain wiring keeps every pulse one cycle wide
   assign tx_evt_o   = req_i[6:0];
   assign rx_evt_o   = req_i[9:7];
   assign tx_adv_o   = req_i[10];
   assign tx_wrap_o  = req_i[11];
   assign rx_start_o = req_i[12];
   assign rx_adv_o   = req_i[13];
   assign rx_wrap_o  = req_i[14];
endmodule
`default_nettype wire

// File: tb_emac_queue_status.sv
// Bench: APB sequences with expected values.
// Assumes zero-wait APB and the DMA model for engine pulses.
`default_nettype none
module tb_emac_queue_status;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CTL = emac_qs_pkg::OFS_CONTROL;
   localparam logic [7:0] NS  = emac_qs_pkg::OFS_NET_STATUS;
   localparam logic [7:0] TS  = emac_qs_pkg::OFS_TX_STATUS;
   localparam logic [7:0] RQ  = emac_qs_pkg::OFS_RX_QPTR;
   localparam logic [7:0] TQ  = emac_qs_pkg::OFS_TX_QPTR;
   localparam logic [7:0] RS  = emac_qs_pkg::OFS_RX_STATUS;
   logic clk, rst_n, psel, pen, pwr, mdio, busy, act, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, txa, rxa;
   logic [14:0] req;
   logic [3:0]  snap;
   emac_qs_pkg::tx_evt_s tx_evt;
   emac_qs_pkg::rx_evt_s rx_evt;
   logic tx_adv, tx_wrap, rx_st, rx_adv, rx_wrap, stop, ter, fcs, refetch, txf, rxf, ten, ren;
   int failures, tests_run;
   emac_dma_model mdl (.req_i(req), .tx_evt_o(tx_evt), .rx_evt_o(rx_evt), .tx_adv_o(tx_adv),
      .tx_wrap_o(tx_wrap), .rx_start_o(rx_st), .rx_adv_o(rx_adv), .rx_wrap_o(rx_wrap));
   // Small index width so the wrap count is reachable
   emac_queue_status #(.IDX_W(3)) dut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .MDIO_PIN_I(mdio), .MGMT_BUSY_I(busy),
      .TX_ACTIVE_I(act), .TX_EVT_I(tx_evt), .TX_DESC_ADV_I(tx_adv), .TX_DESC_WRAP_I(tx_wrap),
      .RX_EVT_I(rx_evt), .RX_FRAME_START_I(rx_st), .RX_DESC_ADV_I(rx_adv),
      .RX_DESC_WRAP_I(rx_wrap), .TRANSMIT_ENABLE_O(ten), .RECEIVE_ENABLE_O(ren),
      .TX_STOP_O(stop), .TX_FLUSH_O(txf), .RX_FLUSH_O(rxf), .TX_ER_O(ter),
      .TX_BAD_FCS_O(fcs), .RX_REFETCH_O(refetch), .TX_DESC_ADDR_O(txa), .RX_DESC_ADDR_O(rxa));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // APB transfer; request held until pready seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         failures++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   // One-cycle engine pulse; outputs caught one cycle later
   task automatic ev(input logic [14:0] b);
      @(posedge clk);
      req <= b;
      @(posedge clk);
      req <= 15'h0000;
      #1 snap = {stop, ter, fcs, refetch};
   endtask
   initial begin
      {rst_n, psel, pen, pwr, busy, act} = 6'h00;
      mdio = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      req = 15'h0000;
      failures = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      // Pin synchroniser needs two edges before the live level shows
      repeat (2) @(posedge clk);
      rdchk("nsr", NS, 32'h6);
      mdio <= 1'b0;
      busy <= 1'b1;
      repeat (3) @(posedge clk);
      rdchk("nsr", NS, 32'h0);
      // Transmit flags, clearing by ones
      ev(15'h0077);
      rdchk("tsr", TS, 32'h77);
      apb(1'b1, TS, 32'h5);
      rdchk("tsr", TS, 32'h72);
      apb(1'b1, TS, 32'h0);
      rdchk("tsr", TS, 32'h72);
      apb(1'b1, TS, 32'hFFFF_FFFF);
      act <= 1'b1;
      rdchk("tsr", TS, 32'h8);
      act <= 1'b0;
      ev(15'h0010);
      chk("pulses", 32'hE, {28'h0, snap});
      ev(15'h0040);
      chk("pulses", 32'h2, {28'h0, snap});
      // Receive flags and refetch
      ev(15'h0380);
      rdchk("rsr", RS, 32'h7);
      apb(1'b1, RS, 32'h7);
      rdchk("rsr", RS, 32'h0);
      apb(1'b1, CTL, 32'hC);
      rdchk("ctl", CTL, 32'hC);
      chk("enables", 32'h3, {30'h0, ten, ren});
      ev(15'h0080);
      rdchk("rsr", RS, 32'h1);
      ev(15'h1000);
      chk("refetch", 32'h1, {28'h0, snap});
      ev(15'h2000);
      ev(15'h1000);
      chk("refetch", 32'h0, {28'h0, snap});
      // Queue pointers; low two bits kept zero
      apb(1'b1, RQ, 32'h0000_1003);
      rdchk("rqp", RQ, 32'h0000_1000);
      ev(15'h2000);
      rdchk("rqp", RQ, 32'h0000_1008);
      chk("rxaddr", 32'h0000_1008, rxa);
      ev(15'h6000);
      rdchk("rqp", RQ, 32'h0000_1000);
      for (int i = 0; i < 8; i++) ev(15'h2000);
      rdchk("rqp", RQ, 32'h0000_1000);
      ev(15'h2000);
      apb(1'b1, CTL, 32'h8);
      #1 chk("flush", 32'h1, {29'h0, stop, txf, rxf});
      rdchk("rqp", RQ, 32'h0000_1008);
      apb(1'b1, TQ, 32'h0000_2000);
      ev(15'h0400);
      rdchk("tqp", TQ, 32'h0000_2008);
      act <= 1'b1;
      ev(15'h0400);
      rdchk("tqp", TQ, 32'h0000_2008);
      chk("txaddr", 32'h0000_2010, txa);
      act <= 1'b0;
      apb(1'b1, CTL, 32'h0);
      #1 chk("flush", 32'h6, {29'h0, stop, txf, rxf});
      rdchk("tqp", TQ, 32'h0000_2000);
      // Unmapped place answers with an error
      apb(1'b0, 8'h44, 32'h0);
      chk("err", 32'h1, {31'h0, err});
      chk("unmapped", 32'h0, rd);
      end_sim();
   end
endmodule
`default_nettype wire
